/* design/adcc_conversion_control.v */
// Converter control, clock divider, approximation sequencer and APB slave
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.vh"
module adcc_conversion_control #(
   parameter CH_COUNT = `ADCC_NUM_CH,
   parameter STEPS = `ADCC_CONV_STEPS,
   parameter SETTLE_CYC = `ADCC_SETTLE_CYC
) (
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire halt_mode,
   input wire wait_mode,
   input wire [CH_COUNT-1:0] analog_pin_level,
   output wire [CH_COUNT-1:0] pin_logic_level,
   input wire comparator_high,
   output reg [2:0] input_channel_select,
   output wire [9:0] trial_code,
   output reg sample_hold,
   output wire converter_powered,
   output wire interrupt_request
);
   // Control/status fields
   reg conv_done; // End-of-conversion flag
   reg clk_fast; // Fast select bit
   reg converter_on; // Converter enable
   reg clk_half; // Half select bit
   // Sequencer state
   localparam ST_IDLE = 2'd0;
   localparam ST_SETTLE = 2'd1;
   localparam ST_SAMPLE = 2'd2;
   localparam ST_CONVERT = 2'd3;
   reg [1:0] state;
   reg [9:0] sar; // Approximation register
   reg [3:0] bit_idx; // Bit under trial
   reg [15:0] settle_cnt; // Settling counter after halt
   reg [1:0] div_cnt; // Conversion clock prescaler
   reg halt_seen; // Halt happened since last settle
   reg done_pulse; // One-cycle completion strobe
   wire [9:0] trial_bit;
   wire [9:0] stored_high;
   wire [7:0] high_byte;
   wire [1:0] low_bits;
   wire locked;
   wire [7:0] csr_value;
   wire [15:0] settle_value;
   wire access;
   wire wr_csr;
   wire rd_high;
   wire rd_low;
   wire unmapped;
   reg conv_tick;
   reg [31:0] next_rdata;

   // Single-cycle APB answer
   assign access = psel && penable;
   assign pready = 1'b1;
   assign wr_csr = access && pwrite && (paddr == `ADCC_OFF_CSR);
   assign rd_high = access && !pwrite && (paddr == `ADCC_OFF_HIGH);
   assign rd_low = access && !pwrite && (paddr == `ADCC_OFF_LOW);
   assign unmapped = (paddr != `ADCC_OFF_CSR) && (paddr != `ADCC_OFF_HIGH) &&
                     (paddr != `ADCC_OFF_LOW) && (paddr != `ADCC_OFF_SETTLE);
   assign pslverr = access && unmapped;
   assign csr_value = {conv_done, clk_fast, converter_on, clk_half, 1'b0, input_channel_select};
   assign settle_value = settle_cnt;
   assign stored_high = {high_byte, low_bits};
   assign interrupt_request = 1'b0; // Polling only
   assign pin_logic_level = analog_pin_level; // Digital path kept
   assign converter_powered = converter_on && !halt_mode;
   assign trial_bit = 10'h001 << bit_idx;
   assign trial_code = sar | trial_bit;

   // Read multiplexer, zeros above narrow data
   always @* begin
      next_rdata = 32'h0000_0000;
      if (paddr == `ADCC_OFF_CSR) begin
         next_rdata = {24'h00_0000, csr_value};
      end else if (paddr == `ADCC_OFF_HIGH) begin
         next_rdata = {24'h00_0000, stored_high[9:2]};
      end else if (paddr == `ADCC_OFF_LOW) begin
         next_rdata = {30'h0000_0000, stored_high[1:0]};
      end else if (paddr == `ADCC_OFF_SETTLE) begin
         next_rdata = {16'h0000, settle_value};
      end
   end
   assign prdata = next_rdata;

   // Conversion clock select from the two bits
   always @* begin
      case ({clk_fast, clk_half})
         2'b10: conv_tick = 1'b1; // CPU clock
         2'b11: conv_tick = div_cnt[0]; // Divide by 2
         2'b00: conv_tick = div_cnt[0]; // Divide by 2
         2'b01: conv_tick = (div_cnt == 2'b11); // Divide by 4
         default: conv_tick = 1'b0;
      endcase
   end

   // Control/status register and completion flag
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_done <= 1'b0;
         clk_fast <= 1'b0;
         converter_on <= 1'b0;
         clk_half <= 1'b0;
         input_channel_select <= 3'h0;
      end else if (clk_en) begin
         if (wr_csr) begin
            // Top bit and bit 3 not writable
            clk_fast <= pwdata[`ADCC_BIT_FAST];
            converter_on <= pwdata[`ADCC_BIT_ON];
            clk_half <= pwdata[`ADCC_BIT_HALF];
            input_channel_select <= pwdata[2:0];
         end
         // Set wins over a clear in the same cycle
         if (done_pulse) begin
            conv_done <= 1'b1;
         end else if (wr_csr || rd_high) begin
            conv_done <= 1'b0;
         end
      end
   end

   // Divider runs only while the converter is powered
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= 2'h0;
      end else if (clk_en) begin
         div_cnt <= converter_powered ? div_cnt + 2'h1 : 2'h0;
      end
   end

   // Approximation sequencer
   // Channels 6 and 7 are not wired; the result then is whatever the comparator says.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         sar <= 10'h000;
         bit_idx <= 4'h0;
         settle_cnt <= 16'h0000;
         halt_seen <= 1'b0;
         sample_hold <= 1'b0;
         done_pulse <= 1'b0;
      end else if (clk_en) begin
         done_pulse <= 1'b0;
         if (halt_mode) begin
            halt_seen <= 1'b1; // Remember halt
         end
         // Wait mode is not looked at: conversion carries on
         if (!converter_powered) begin
            state <= ST_IDLE; // Stop at once
            sample_hold <= 1'b0;
         end else begin
            case (state)
               ST_IDLE: begin
                  settle_cnt <= halt_seen ? SETTLE_CYC[15:0] : 16'h0000;
                  halt_seen <= 1'b0;
                  state <= ST_SETTLE;
               end
               ST_SETTLE: begin
                  // Settle after halt wakeup
                  if (settle_cnt == 16'h0000) begin
                     state <= ST_SAMPLE;
                  end else begin
                     settle_cnt <= settle_cnt - 16'h0001;
                  end
               end
               ST_SAMPLE: begin
                  if (conv_tick) begin
                     sample_hold <= 1'b1;
                     sar <= 10'h000;
                     bit_idx <= STEPS[3:0] - 4'h1;
                     state <= ST_CONVERT;
                  end
               end
               ST_CONVERT: begin
                  if (conv_tick) begin
                     // Binary search keeps code monotonic and saturating
                     if (comparator_high) begin
                        sar <= trial_code;
                     end
                     if (bit_idx == 4'h0) begin
                        done_pulse <= 1'b1;
                        sample_hold <= 1'b0;
                        state <= ST_SAMPLE; // Next conversion at once
                     end else begin
                        bit_idx <= bit_idx - 4'h1;
                     end
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // Final code includes last trial decision
   reg [9:0] final_code;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         final_code <= 10'h000;
      end else if (clk_en && state == ST_CONVERT && conv_tick && bit_idx == 4'h0) begin
         final_code <= comparator_high ? trial_code : sar;
      end
   end

   // Result pair with freeze
   adcc_result_store u_store (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .load(done_pulse),
      .result(final_code),
      .low_read(rd_low),
      .high_read(rd_high),
      .high_byte(high_byte),
      .low_bits(low_bits),
      .locked(locked)
   );
   wire unused_ok = locked | wait_mode;
endmodule // adcc_conversion_control
`default_nettype wire

/* design/adcc_defines.vh */
// Constants for the converter control block
// Contract
// - Three-bit field picks one of six inputs
// - Converter-on starts continuous back-to-back conversions
// - Clearing converter-on stops conversion, saves power
// - Completion sets flag, loads both result bytes
// - High-byte read or status write clears flag
// - Low-byte read freezes high byte until read
// - Above high reference gives all-ones result
// - Below low reference gives zero result
// - Result code is monotonic in input
// - Status resets zero, bit7 read-only, bit3 zero
// - Wait no effect; halt disables, then settle
// - Analog pins stay readable as logic inputs
// - Two select bits pick CPU clock divider
// - Codes 000 to 101 select inputs 0-5
// - High byte bits 9:2, low byte 1:0
`ifndef ADCC_DEFINES_VH
`define ADCC_DEFINES_VH
`define ADCC_OFF_LOW 12'h000
`define ADCC_OFF_HIGH 12'h004
`define ADCC_OFF_CSR 12'h008
`define ADCC_OFF_SETTLE 12'h00c
`define ADCC_CSR_RESET 8'h00
`define ADCC_BIT_DONE 7
`define ADCC_BIT_FAST 6
`define ADCC_BIT_ON 5
`define ADCC_BIT_HALF 4
`define ADCC_CSR_WMASK 8'h77
`define ADCC_NUM_CH 6
`define ADCC_CONV_STEPS 10
`define ADCC_SETTLE_NS 1000
`define ADCC_CLK_NS 40
`define ADCC_SETTLE_CYC ((`ADCC_SETTLE_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
`endif

/* design/adcc_result_store.v */
// Result holding store with high-byte lock
`timescale 1ns/1ps
`default_nettype none
module adcc_result_store (
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   input wire load,
   input wire [9:0] result,
   input wire low_read,
   input wire high_read,
   output reg [7:0] high_byte,
   output reg [1:0] low_bits,
   output reg locked
);
   // Load, freeze and release the result pair
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         high_byte <= 8'h00;
         low_bits <= 2'h0;
         locked <= 1'b0;
      end else if (clk_en) begin
         if (high_read) begin
            locked <= 1'b0; // Release on high read
         end else if (low_read) begin
            locked <= 1'b1; // Freeze on low read
         end
         // Pair stays consistent while frozen
         if (load && !locked && !low_read) begin
            high_byte <= result[9:2];
            low_bits <= result[1:0];
         end
      end
   end
endmodule // adcc_result_store
`default_nettype wire

/* tb/adcc_monitor.sv */
// Port checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_monitor #(
   parameter CH_COUNT = 6
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic halt_mode,
   input wire logic [CH_COUNT-1:0] analog_pin_level,
   input wire logic [CH_COUNT-1:0] pin_logic_level,
   input wire logic [2:0] input_channel_select,
   input wire logic sample_hold,
   input wire logic converter_powered,
   input wire logic interrupt_request
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel && penable && clk_en; // Access phase taken
   wire wr_csr = acc && pwrite && paddr == 12'h008; // Status register write
   logic on_q; // Shadow of the converter-on bit
   // Shadow follows software writes only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         on_q <= 1'b0;
      else if (wr_csr)
         on_q <= pwdata[5];
   end
   property p_chan;
      wr_csr |=> input_channel_select == $past(pwdata[2:0]);
   endproperty
   a_chan: assert property (p_chan) else $error("channel select not taken");
   property p_pwr;
      converter_powered == (on_q && !halt_mode);
   endproperty
   a_pwr: assert property (p_pwr) else $error("power state wrong");
   property p_off;
      !converter_powered [*4] |-> !sample_hold;
   endproperty
   a_off: assert property (p_off) else $error("sampling while off");
   property p_irq;
      !interrupt_request;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt raised");
   property p_pins;
      pin_logic_level == analog_pin_level;
   endproperty
   a_pins: assert property (p_pins) else $error("pin level lost");
   property p_err;
      acc && paddr > 12'h00c |-> pslverr && prdata == 32'h0;
   endproperty
   a_err: assert property (p_err) else $error("unmapped access not refused");
   property p_ok;
      acc && paddr <= 12'h00c && paddr[1:0] == 2'b00 |-> !pslverr;
   endproperty
   a_ok: assert property (p_ok) else $error("mapped access refused");
   property p_csr_rd;
      acc && !pwrite && paddr == 12'h008 |-> prdata[31:8] == 24'h0 && !prdata[3] && prdata[5] == on_q;
   endproperty
   a_csr_rd: assert property (p_csr_rd) else $error("status read wrong");
   property p_low_rd;
      acc && !pwrite && paddr == 12'h000 |-> prdata[31:2] == 30'h0;
   endproperty
   a_low_rd: assert property (p_low_rd) else $error("low byte upper bits set");
   c_full: cover property (acc && !pwrite && paddr == 12'h000 && prdata[1:0] == 2'b11);
   c_err: cover property (pslverr);
   c_halt: cover property (on_q && !converter_powered);
endmodule // adcc_monitor
bind adcc_conversion_control adcc_monitor #(.CH_COUNT(CH_COUNT)) u_adcc_monitor (.pclk(pclk), .presetn(presetn),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pslverr(pslverr), .halt_mode(halt_mode), .analog_pin_level(analog_pin_level),
   .pin_logic_level(pin_logic_level), .input_channel_select(input_channel_select), .sample_hold(sample_hold),
   .converter_powered(converter_powered), .interrupt_request(interrupt_request));
`default_nettype wire

/* tb/test_adcc_conversion_control.sv */
// Directed bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.vh"
module test_adcc_conversion_control;
   localparam [11:0] CSR = `ADCC_OFF_CSR, LO = `ADCC_OFF_LOW, HI = `ADCC_OFF_HIGH;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic halt_mode = 0, wait_mode = 0, comparator_high = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic [5:0] analog_pin_level = 6'h2a; // Fixed pin pattern
   wire [31:0] prdata;
   wire [5:0] pin_logic_level;
   wire [2:0] input_channel_select;
   wire [9:0] trial_code; // Trial value toward the comparator
   wire pready, pslverr, sample_hold, converter_powered, interrupt_request;
   int num_errors = 0, n_compared = 0, t[4];
   logic [31:0] sel[4] = '{32'h60, 32'h70, 32'h20, 32'h30}; // Divide by 1, 2, 2, 4
   always #20 pclk = ~pclk;
   adcc_conversion_control #(.SETTLE_CYC(2)) u_adcc_conversion_control (
      .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .halt_mode(halt_mode), .wait_mode(wait_mode), .analog_pin_level(analog_pin_level),
      .pin_logic_level(pin_logic_level), .comparator_high(comparator_high), .trial_code(trial_code),
      .input_channel_select(input_channel_select), .sample_hold(sample_hold),
      .converter_powered(converter_powered), .interrupt_request(interrupt_request));
   // One APB transfer; data and error taken at the pready edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge so a following call never reassigns psel in this time step
      @(posedge pclk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdx(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // Poll the done flag, bounded; count of polls kept as a time measure
   task automatic poll(output int n);
      n = 0;
      rd = 32'h0;
      while (rd[7] !== 1'b1 && n < 400) begin
         apb(1'b0, CSR, 32'h0);
         n++;
      end
      chk(rd[7], 1'b1);
   endtask
   task test_done();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdx(CSR, 32'h0);
      chk(trial_code, 32'h1);
      rdx(LO, 32'h0);
      rdx(HI, 32'h0);
      apb(1'b1, CSR, 32'h9d);
      rdx(CSR, 32'h15);
      for (int c = 0; c < 6; c++) begin
         apb(1'b1, CSR, c);
         rdx(CSR, c);
         chk(input_channel_select, c);
      end
      comparator_high <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, CSR, sel[i] & 32'h50);
         apb(1'b1, CSR, sel[i]);
         poll(t[i]);
      end
      chk(t[0] < t[2] && t[2] < t[3] && (t[1] - t[2]) inside {[-1:1]}, 1'b1);
      rdx(HI, 32'hff);
      rdx(CSR, 32'h30);
      poll(t[0]);
      rdx(LO, 32'h3);
      comparator_high <= 1'b0;
      repeat (150) @(posedge pclk);
      rdx(HI, 32'hff);
      // Converter off during the check, so no completion can race the clear
      apb(1'b1, CSR, 32'h10);
      rdx(CSR, 32'h10);
      apb(1'b1, CSR, 32'h30);
      poll(t[0]);
      rdx(LO, 32'h0);
      rdx(HI, 32'h0);
      apb(1'b1, CSR, 32'h0);
      repeat (60) @(posedge pclk);
      chk(sample_hold, 1'b0);
      rdx(CSR, 32'h0);
      apb(1'b1, CSR, 32'h60);
      halt_mode <= 1'b1;
      wait_mode <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(converter_powered, 1'b0);
      halt_mode <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(converter_powered, 1'b1);
      poll(t[0]);
      apb(1'b0, 12'h010, 32'h0);
      chk(er, 32'h1);
      chk(rd, 32'h0);
      chk(pin_logic_level, analog_pin_level);
      chk(interrupt_request, 1'b0);
      test_done();
   end
   // Watchdog well beyond the expected run length
   initial begin
      #400us;
      num_errors++;
      test_done();
   end
endmodule // test_adcc_conversion_control
`default_nettype wire
